// ===== design/bsawc_regs.vh
// constants for the burst sram address and write control front end
`ifndef BSAWC_REGS_VH
`define BSAWC_REGS_VH
`define BSAWC_ADDR_W 20
`define BSAWC_LANES 2
`define BSAWC_SEED_W 2
`define BSAWC_SEED_RST 2'h0
`define BSAWC_STRAP_RST 1'h1
`define BSAWC_ADDR_RST 20'h00000
`define BSAWC_OP_IDLE 2'h0
`define BSAWC_OP_READ 2'h1
`define BSAWC_OP_WRITE 2'h2
`endif

// ===== design/bsawc_burst_seq.v
// burst offset generator: linear or interleaved order from a two-bit count
`timescale 1ns/1ps
`default_nettype none
`include "bsawc_regs.vh"
module bsawc_burst_seq (
    input wire [1:0] seedBits,
    input wire [1:0] stepCount,
    input wire interleaveMode,
    output reg [1:0] burstOffset
);
    always @* begin
        if (interleaveMode) begin
            burstOffset = seedBits ^ stepCount;
        end else begin
            burstOffset = seedBits + stepCount;
        end
    end
endmodule // bsawc_burst_seq
`default_nettype wire

// ===== design/bsawc_front_end.v
// address capture, burst counter and write decode of the burst sram
`timescale 1ns/1ps
`default_nettype none
`include "bsawc_regs.vh"
// Overview of operation
// - strap low gives linear burst order, high gives interleaved order.
// - address captured when a strobe is low and all chip enables active.
// - on capture the two low address bits seed the burst counter.
// - a lane writes when its select and the lane write enable are low.
// - global write enable low writes every lane regardless of selects.
// - with both strobes low only the processor strobe is acted on.
// - processor strobe ignored when the first chip enable is high.
// - burst address steps on each edge with the advance input low.
// - second enable active high, first and third active low; all needed.
module bsawc_front_end #(
    parameter ADDR_W = `BSAWC_ADDR_W,
    parameter LANES = `BSAWC_LANES
) (
    input wire clk,
    input wire reset_n,
    input wire [ADDR_W-1:0] addrIn,
    input wire procAddrStrobe_n,
    input wire ctrlAddrStrobe_n,
    input wire burstStep_n,
    input wire chipSelFirst_n,
    input wire chipSelSecond,
    input wire chipSelThird_n,
    input wire [LANES-1:0] laneWriteSel_n,
    input wire allLanesWrite_n,
    input wire laneWriteEnable_n,
    input wire burstOrderStrap,
    output reg [ADDR_W-1:0] memAddr_q,
    output reg [LANES-1:0] laneWrite_q,
    output reg [1:0] accessOp_q,
    output reg captured_q
);
    // per lane: global write overrides the lane select
    function laneDecode;
        input laneSel_n;
        input gw_n;
        input bwe_n;
        begin
            if (!gw_n) begin
                laneDecode = 1'h1;
            end else if (!bwe_n) begin
                laneDecode = !laneSel_n;
            end else begin
                laneDecode = 1'h0;
            end
        end
    endfunction

    function chipEnabled;
        input first_n;
        input second;
        input third_n;
        begin
            chipEnabled = !first_n && second && !third_n;
        end
    endfunction

    // controller strobe loses when the processor strobe is also low
    function strobeTaken;
        input proc_n;
        input ctrl_n;
        input first_n;
        reg procOk;
        reg ctrlOk;
        begin
            procOk = !proc_n && !first_n;
            ctrlOk = !ctrl_n && proc_n;
            strobeTaken = procOk || ctrlOk;
        end
    endfunction

    function [1:0] opDecode;
        input [LANES-1:0] lanes;
        begin
            if (|lanes) begin
                opDecode = `BSAWC_OP_WRITE;
            end else begin
                opDecode = `BSAWC_OP_READ;
            end
        end
    endfunction

    wire chipSelected;
    wire startAccess;
    wire continuing;
    wire [LANES-1:0] laneDec;
    wire [1:0] burstOffset;
    wire [ADDR_W-1:0] stepAddr;
    reg [ADDR_W-1:0] baseAddr_q;
    reg [ADDR_W-1:0] baseAddr_d;
    reg [ADDR_W-1:0] memAddr_d;
    reg [1:0] stepCount_q;
    reg [1:0] stepCount_d;
    reg active_q;
    reg active_d;
    reg strap_q;
    reg [LANES-1:0] laneWrite_d;
    reg [1:0] accessOp_d;
    reg captured_d;
    genvar lane;

    assign chipSelected = chipEnabled(chipSelFirst_n, chipSelSecond,
        chipSelThird_n);
    assign startAccess = chipSelected && strobeTaken(procAddrStrobe_n,
        ctrlAddrStrobe_n, chipSelFirst_n);
    // every edge after the first capture counts as a burst edge
    assign continuing = startAccess || active_q;
    // upper bits stay put; only the two-bit offset walks
    assign stepAddr = {baseAddr_q[ADDR_W-1:2], burstOffset};

    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            assign laneDec[lane] = laneDecode(laneWriteSel_n[lane],
                allLanesWrite_n, laneWriteEnable_n);
        end
    endgenerate

    bsawc_burst_seq u_seq (
        .seedBits(baseAddr_q[1:0]),
        .stepCount(stepCount_d),
        .interleaveMode(strap_q),
        .burstOffset(burstOffset)
    );

    // two-bit count wraps, so a burst is four words long
    always @* begin
        if (startAccess) begin
            stepCount_d = 2'h0;
        end else if (active_q && !burstStep_n) begin
            stepCount_d = stepCount_q + 2'h1;
        end else begin
            stepCount_d = stepCount_q;
        end
    end

    always @* begin
        baseAddr_d = baseAddr_q;
        active_d = active_q;
        memAddr_d = memAddr_q;
        if (startAccess) begin
            baseAddr_d = addrIn;
            active_d = 1'h1;
            memAddr_d = addrIn;
        end else if (active_q) begin
            memAddr_d = stepAddr;
        end
    end

    // write strobes follow the lane decode on every edge once active_q is set; before that an idle edge clears them
    always @* begin
        captured_d = startAccess;
        if (continuing) begin
            laneWrite_d = laneDec;
            accessOp_d = opDecode(laneDec);
        end else begin
            laneWrite_d = {LANES{1'h0}};
            accessOp_d = `BSAWC_OP_IDLE;
        end
    end

    // strap is meant to be static; resampled each cycle, no glitch guard
    always @(posedge clk) begin
        if (!reset_n) begin
            strap_q <= `BSAWC_STRAP_RST;
        end else begin
            strap_q <= burstOrderStrap;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            stepCount_q <= `BSAWC_SEED_RST;
        end else begin
            stepCount_q <= stepCount_d;
        end
    end

    // never cleared: no deselect cycle in this front end, a limitation
    always @(posedge clk) begin
        if (!reset_n) begin
            active_q <= 1'h0;
        end else begin
            active_q <= active_d;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            baseAddr_q <= `BSAWC_ADDR_RST;
        end else begin
            baseAddr_q <= baseAddr_d;
        end
    end

    // held unless captured or stepped
    always @(posedge clk) begin
        if (!reset_n) begin
            memAddr_q <= `BSAWC_ADDR_RST;
        end else begin
            memAddr_q <= memAddr_d;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            laneWrite_q <= {LANES{1'h0}};
            accessOp_q <= `BSAWC_OP_IDLE;
            captured_q <= 1'h0;
        end else begin
            laneWrite_q <= laneWrite_d;
            accessOp_q <= accessOp_d;
            captured_q <= captured_d;
        end
    end
endmodule // bsawc_front_end
`default_nettype wire

// ===== sim/bsawc_front_end_assertions.sv
// assertions for the burst sram front end
`timescale 1ns/1ps
`default_nettype none
`include "bsawc_regs.vh"
module bsawc_fe_checker #(parameter ADDR_W = 20) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic procAddrStrobe_n,
    input wire logic ctrlAddrStrobe_n,
    input wire logic burstStep_n,
    input wire logic chipSelFirst_n,
    input wire logic chipSelSecond,
    input wire logic chipSelThird_n,
    input wire logic captured_q,
    input wire logic allLanesWrite_n,
    input wire logic laneWriteEnable_n,
    input wire logic burstOrderStrap,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [ADDR_W-1:0] memAddr_q,
    input wire logic [1:0] laneWriteSel_n,
    input wire logic [1:0] laneWrite_q,
    input wire logic [1:0] accessOp_q
);
    wire sel = !chipSelFirst_n && chipSelSecond && !chipSelThird_n;
    wire tk = sel && !(procAddrStrobe_n && ctrlAddrStrobe_n);
    wire st = captured_q && !tk && !burstStep_n;
    wire wb = allLanesWrite_n && !laneWriteEnable_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_cap; tk |=> captured_q && memAddr_q == $past(addrIn); endproperty
    a_cap: assert property (p_cap) else $error("cap");
    property p_ign; !tk |=> !captured_q; endproperty
    a_ign: assert property (p_ign) else $error("ign");
    property p_gw; tk && !allLanesWrite_n |=> laneWrite_q == 2'h3; endproperty
    a_gw: assert property (p_gw) else $error("gw");
    property p_bw; tk && wb |=> laneWrite_q == ~$past(laneWriteSel_n); endproperty
    a_bw: assert property (p_bw) else $error("bw");
    property p_rd; tk && allLanesWrite_n && laneWriteEnable_n
        |=> accessOp_q == `BSAWC_OP_READ; endproperty
    a_rd: assert property (p_rd) else $error("rd");
    property p_lin; st && !burstOrderStrap
        |=> memAddr_q[1:0] == $past(memAddr_q[1:0]) + 2'h1; endproperty
    a_lin: assert property (p_lin) else $error("lin");
    property p_il; st && burstOrderStrap
        |=> memAddr_q[1:0] == ($past(memAddr_q[1:0]) ^ 2'h1); endproperty
    a_il: assert property (p_il) else $error("il");
    property p_hold; !tk && burstStep_n |=> $stable(memAddr_q); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    c_cap: cover property (tk ##1 captured_q);
    c_st: cover property (st);
    c_wr: cover property (accessOp_q == `BSAWC_OP_WRITE);
endmodule // bsawc_fe_checker
bind bsawc_front_end bsawc_fe_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .reset_n(reset_n),
    .procAddrStrobe_n(procAddrStrobe_n), .ctrlAddrStrobe_n(ctrlAddrStrobe_n),
    .burstStep_n(burstStep_n), .chipSelFirst_n(chipSelFirst_n),
    .chipSelSecond(chipSelSecond), .chipSelThird_n(chipSelThird_n),
    .captured_q(captured_q), .allLanesWrite_n(allLanesWrite_n),
    .laneWriteEnable_n(laneWriteEnable_n), .burstOrderStrap(burstOrderStrap),
    .addrIn(addrIn), .memAddr_q(memAddr_q),
    .laneWriteSel_n(laneWriteSel_n), .laneWrite_q(laneWrite_q),
    .accessOp_q(accessOp_q)
);
`default_nettype wire

// ===== sim/bsawc_ctrl_model.sv
// controller-side bus model driving the sram front end
`timescale 1ns/1ps
`default_nettype none
module bsawc_ctrl_model (
    input wire logic clk,
    output logic [5:0] ctl,
    output logic [19:0] adr,
    output logic [3:0] wr
);
    initial {ctl, adr, wr} = {6'h3a, 20'h00000, 4'hf};
    task req(input logic [5:0] c, input logic [19:0] a, input logic [3:0] w);
        @(negedge clk);
        // no strobe: bus not held, show the inverse of the last address
        adr = (c[5] && c[4]) ? ~adr : a;
        ctl = c;
        wr = w;
    endtask
endmodule // bsawc_ctrl_model
`default_nettype wire

// ===== sim/bsawc_testbench.sv
// self-checking bench for the burst sram front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, reset_n = 0, strap = 0;
    int mismatches = 0, total_checks = 0, cyc = 0;
    wire logic [5:0] c;
    wire logic [19:0] a;
    wire logic [3:0] w;
    wire logic [24:0] o;
    always #25 clk = ~clk;
    bsawc_ctrl_model P (.clk(clk), .ctl(c), .adr(a), .wr(w));
    bsawc_front_end DUT (.clk(clk), .reset_n(reset_n), .addrIn(a),
        .procAddrStrobe_n(c[5]), .ctrlAddrStrobe_n(c[4]), .burstStep_n(c[3]),
        .chipSelFirst_n(c[2]), .chipSelSecond(c[1]), .chipSelThird_n(c[0]),
        .allLanesWrite_n(w[3]), .laneWriteEnable_n(w[2]),
        .laneWriteSel_n(w[1:0]), .burstOrderStrap(strap), .captured_q(o[24]),
        .accessOp_q(o[23:22]), .laneWrite_q(o[21:20]), .memAddr_q(o[19:0]));
    task chk(input logic [24:0] s, e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 400) begin mismatches++; stop_test; end
    task rst(input logic s);
        reset_n = 0;
        strap = s;
        repeat (3) @(negedge clk);
        reset_n = 1;
    endtask
    task t_acc(input logic [5:0] s, input logic [19:0] d,
        input logic [3:0] v, input logic [4:0] e);
        P.req(s, d, v);
        P.req(6'h3a, d, 4'hf);
        chk(o, {e, d});
    endtask
    task t_ref(input logic [5:0] s);
        P.req(s, 20'h33333, 4'h7);
        P.req(6'h3a, 20'h0, 4'hf);
        chk({o[24], o[19:0]}, {1'h0, 20'h70707});
    endtask
    task t_burst(input logic [19:0] d, input logic [7:0] ex);
        P.req(6'h1a, d, 4'hf);
        for (int i = 3; i >= 0; i--) begin
            P.req(6'h32, d, 4'hf);
            chk(o[19:0], {d[19:2], ex[2*i+:2]});
        end
    endtask
    initial begin
        rst(0);
        t_acc(6'h1a, 20'h12345, 4'hf, 5'h14);
        t_acc(6'h2a, 20'habcde, 4'h7, 5'h1b);
        t_acc(6'h0a, 20'h00f0f, 4'ha, 5'h19);
        t_acc(6'h1a, 20'h70707, 4'hc, 5'h14);
        t_ref(6'h1e);
        t_ref(6'h28);
        t_ref(6'h2b);
        t_burst(20'hf00c3, 8'hc6);
        rst(1);
        t_burst(20'h2a5d1, 8'h4e);
        stop_test;
    end
endmodule // testbench
`default_nettype wire
